// ===== hdl/tag_sel_regs.svh
/*
 * Constants of the tag-kind selector: character codes of the command
 * telegram, status characters and reset values of the stored kinds.
 * Assumes ASCII text on the serial link, already split into bytes.
 */
`ifndef TAG_SEL_REGS_SVH
`define TAG_SEL_REGS_SVH

// ----------------------------------------------------------------
// telegram characters
// ----------------------------------------------------------------
`define TS_ETX          8'h03
`define TS_CASE_BIT     8'h20
`define TS_CHAR_C       8'h63
`define TS_CHAR_T       8'h74
`define TS_CHAR_X       8'h78
`define TS_CHAR_ZERO    8'h30
`define TS_CHAR_ONE     8'h31
`define TS_CHAR_NINE    8'h39
`define TS_CHAR_SPACE   8'h20

// ----------------------------------------------------------------
// telegram layout: letters, channel, two code digits, checksum
// ----------------------------------------------------------------
`define TS_POS_CMD0     3'h0
`define TS_POS_CMD1     3'h1
`define TS_POS_CHAN     3'h2
`define TS_POS_HI       3'h3
`define TS_POS_LO       3'h4
`define TS_POS_CHK      3'h5
`define TS_POS_DONE     3'h6
`define TS_RESP_LEN     2'h3

// ----------------------------------------------------------------
// status characters and reset values
// ----------------------------------------------------------------
`define TS_ST_OK        8'h30
`define TS_ST_BAD       8'h34
`define TS_KIND_DEFER   16'h3939
`define TS_BLOCK_STD    4'h4
`define TS_BLOCK_WIDE   4'h8

`endif

// ===== hdl/tag_sel_pkg.sv
/*
 * Types shared by the tag-kind selector modules.
 * Assumes the constants header is compiled alongside.
 */
package tag_sel_pkg;

    typedef logic [15:0] kind_code_type;

    typedef enum logic [1:0] {
        ph_parse,
        ph_apply,
        ph_reply
    } phase_type;

endpackage

// ===== hdl/tag_kind_if.sv
/*
 * Carrier between the selector and its kind decoder: a two-character
 * kind code in, the properties of that kind out.
 * Assumes the decoder is purely combinational.
 */
interface tag_kind_if;
    tag_sel_pkg::kind_code_type code;       // two ascii digits, high first
    logic                       supported;  // code names a known kind
    logic                       uid_only;   // generic uid-only selection
    logic                       block8;     // memory in 8-byte blocks
    logic                       uid_flex;   // uid of 4 or 7 bytes
    logic                       defer;      // head default applies

    modport decoder (input code, output supported, uid_only, block8, uid_flex, defer);
    modport user    (output code, input supported, uid_only, block8, uid_flex, defer);
endinterface

// ===== hdl/tag_kind_table.sv
/*
 * Kind decoder: classifies a two-character kind code.
 * Assumes the code is ascii and may be any value.
 */
`include "tag_sel_regs.svh"

module tag_kind_table (
    tag_kind_if.decoder kind  // code in, properties out
);
    import tag_sel_pkg::*;

    always_comb begin
        kind.supported = 1'b1;
        case (kind.code)
            16'h3032, 16'h3033, 16'h3131, 16'h3132,
            16'h3230, 16'h3231, 16'h3232, 16'h3233, 16'h3234,
            16'h3331, 16'h3333, 16'h3334, 16'h3335,
            16'h3430, 16'h3431, 16'h3432, 16'h3433,
            16'h3530, 16'h3532,
            16'h3732, 16'h3733, 16'h3734, 16'h3735, 16'h3736,
            16'h3830, 16'h3939: kind.supported = 1'b1;
            default: kind.supported = 1'b0;
        endcase
    end

    // [R3] generic uid read
    assign kind.uid_only = (kind.code == 16'h3230);
    // [R4] 8-byte block kind
    assign kind.block8   = (kind.code == 16'h3333);
    // [R10] 4 or 7 byte uid
    assign kind.uid_flex = (kind.code == 16'h3430) || (kind.code == 16'h3432) || (kind.code == 16'h3433);
    // [R7] defer to head
    assign kind.defer    = (kind.code == `TS_KIND_DEFER);

endmodule // tag_kind_table

// ===== hdl/rfid_tag_type_selector.sv
/*
 * Tag-kind selector: parses the kind-choose telegram from the host byte
 * stream, keeps one kind per head channel, mirrors every change to the
 * non-volatile store and answers with status, channel, checksum, end.
 * Assumes: byte stream synchronous to clk_sys; the non-volatile store
 * takes one write per pulse and presents its content at power-up.
 */
`include "tag_sel_regs.svh"

// Contract
// [R1] choose command sets one head's kind, then replies status, channel, checksum, end
// [R2] every chosen kind is written to the non-volatile store
// [R3] code 20 is a generic selection reading only the 8-byte uid
// [R4] the 8-byte-block kind moves data in 8-byte units, not 4
// [R5] host gives even block count of 8-byte blocks, at most seven
// [R6] host gives a contiguous start address for word commands on that kind
// [R7] code 99 imposes nothing; the head's own default kind applies
// [R8] factory default for every channel is code 99
// [R9] channel character x applies the command to all channels
// [R10] 14443A kinds with varying uid accept 4 or 7 byte identifiers
// [R11] host should fix one kind permanently where a plant uses only one
// [R12] command letters in either case; no spaces allowed in parameters
// [R13] unsupported kind code gives error status, stored kinds unchanged
module rfid_tag_type_selector #(
    parameter int NUM_CH = 4
) (
    input  wire logic                                   clk_sys,        // system clock, 50 MHz
    input  wire logic                                   reset_n,        // asynchronous reset
    input  wire logic                                   ce,             // clock enable, freezes all state except the reset release
    input  wire logic                                   rx_valid,       // host byte present
    input  wire logic [7:0]                             rx_data,        // host byte
    output      logic                                   rx_ready,       // host byte taken
    output      logic                                   tx_valid,       // reply byte present
    output      logic [7:0]                             tx_data,        // reply byte
    input  wire logic                                   tx_ready,       // reply byte taken
    input  wire logic                                   factory_reset,  // restore factory kinds
    input  wire tag_sel_pkg::kind_code_type [NUM_CH-1:0] nv_load_kind,  // stored kinds at power-up
    output      logic                                   nv_wr_valid,    // store write pulse
    output      logic [NUM_CH-1:0]                      nv_wr_mask,     // channels written
    output      tag_sel_pkg::kind_code_type             nv_wr_kind,     // kind written
    output      tag_sel_pkg::kind_code_type [NUM_CH-1:0] head_kind,     // kind per head
    output      logic [NUM_CH-1:0]                      head_defer,     // head keeps own default
    output      logic [NUM_CH-1:0]                      head_uid_only,  // uid read only
    output      logic [NUM_CH-1:0]                      head_uid_flex,  // 4 or 7 byte uid
    output      logic [NUM_CH-1:0][3:0]                 head_block_bytes // bytes per memory block
);
    import tag_sel_pkg::*;

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // channel digits are single characters '1'..'9'
    if (NUM_CH < 1 || NUM_CH > 9) begin : g_bad_num_ch
        $error("NUM_CH must lie between 1 and 9");
    end

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        phase_type                    phase;
        logic                         loaded;
        logic [2:0]                   pos;
        logic                         err;
        logic [7:0]                   chan;
        kind_code_type                cand;
        logic [7:0]                   status;
        logic [1:0]                   ridx;
        logic [7:0]                   tx;
        logic                         nv_wr;
        logic [NUM_CH-1:0]            nv_mask;
        kind_code_type                nv_kind;
        kind_code_type [NUM_CH-1:0]   kind;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    // ----------------------------------------------------------------
    // kind decoding
    // ----------------------------------------------------------------
    tag_kind_if cand_if ();
    tag_kind_table u_cand_table (
        .kind (cand_if)
    );
    assign cand_if.code = st_r.cand;

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_head
        tag_kind_if head_if ();
        tag_kind_table u_head_table (
            .kind (head_if)
        );
        assign head_if.code         = st_r.kind[ch];
        assign head_defer[ch]       = head_if.defer;
        assign head_uid_only[ch]    = head_if.uid_only;
        assign head_uid_flex[ch]    = head_if.uid_flex;
        // [R4] block size follows kind
        assign head_block_bytes[ch] = head_if.block8 ? `TS_BLOCK_WIDE : `TS_BLOCK_STD;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    logic [7:0]        rx_lc;
    logic              rx_digit;
    logic              chan_all;
    logic [NUM_CH-1:0] chan_mask;
    logic [7:0]        chk_sum;

    // [R12] fold letters to lower case
    assign rx_lc    = rx_data | `TS_CASE_BIT;
    assign rx_digit = (rx_data >= `TS_CHAR_ZERO) && (rx_data <= `TS_CHAR_NINE);
    // [R9] x reaches every channel
    assign chan_all = ((st_r.chan | `TS_CASE_BIT) == `TS_CHAR_X);
    assign chk_sum  = st_r.status + st_r.chan;

    always_comb begin
        chan_mask = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (chan_all || (st_r.chan == (`TS_CHAR_ONE + 8'(i)))) begin
                chan_mask[i] = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt       = st_r;
        st_nxt.nv_wr = 1'b0;
        rx_ready     = ce && (st_r.phase == ph_parse) && st_r.loaded;

        if (!st_r.loaded) begin
            // contents of the store become active at power-up
            st_nxt.loaded = 1'b1;
            st_nxt.kind   = nv_load_kind;
        end else if (factory_reset) begin
            // [R8] all heads back to deferral
            for (int i = 0; i < NUM_CH; i++) begin
                st_nxt.kind[i] = `TS_KIND_DEFER;
            end
            st_nxt.nv_wr   = 1'b1;
            st_nxt.nv_mask = '1;
            st_nxt.nv_kind = `TS_KIND_DEFER;
            st_nxt.phase   = ph_parse;
            st_nxt.pos     = `TS_POS_CMD0;
            st_nxt.err     = 1'b0;
        end else begin
            case (st_r.phase)
                ph_parse: begin
                    if (rx_valid) begin
                        if (rx_data == `TS_ETX) begin
                            st_nxt.phase = ph_apply;
                            if (st_r.pos != `TS_POS_DONE) begin
                                st_nxt.err = 1'b1;
                            end
                        end else begin
                            if (st_r.pos != `TS_POS_DONE) begin
                                st_nxt.pos = st_r.pos + 3'h1;
                            end
                            case (st_r.pos)
                                `TS_POS_CMD0: begin
                                    // [R12] either case accepted
                                    if (rx_lc != `TS_CHAR_C) begin
                                        st_nxt.err = 1'b1;
                                    end
                                end
                                `TS_POS_CMD1: begin
                                    if (rx_lc != `TS_CHAR_T) begin
                                        st_nxt.err = 1'b1;
                                    end
                                end
                                `TS_POS_CHAN: begin
                                    st_nxt.chan = rx_data;
                                    // [R12] no space in parameters
                                    if (rx_data == `TS_CHAR_SPACE) begin
                                        st_nxt.err = 1'b1;
                                    end
                                end
                                `TS_POS_HI: begin
                                    st_nxt.cand[15:8] = rx_data;
                                    if (!rx_digit) begin
                                        st_nxt.err = 1'b1;
                                    end
                                end
                                `TS_POS_LO: begin
                                    st_nxt.cand[7:0] = rx_data;
                                    if (!rx_digit) begin
                                        st_nxt.err = 1'b1;
                                    end
                                end
                                `TS_POS_CHK: begin
                                    // checksum character is taken but not verified
                                end
                                default: begin
                                    st_nxt.err = 1'b1;
                                end
                            endcase
                        end
                    end
                end

                ph_apply: begin
                    st_nxt.phase = ph_reply;
                    st_nxt.ridx  = 2'h0;
                    // [R13] unknown kind or channel leaves kinds alone
                    if (st_r.err || !cand_if.supported || (chan_mask == '0)) begin
                        st_nxt.status = `TS_ST_BAD;
                    end else begin
                        st_nxt.status = `TS_ST_OK;
                        // [R1] set selected heads
                        for (int i = 0; i < NUM_CH; i++) begin
                            if (chan_mask[i]) begin
                                st_nxt.kind[i] = st_r.cand;
                            end
                        end
                        // [R2] mirror into the store
                        st_nxt.nv_wr   = 1'b1;
                        st_nxt.nv_mask = chan_mask;
                        st_nxt.nv_kind = st_r.cand;
                    end
                    st_nxt.tx = st_nxt.status;
                end

                ph_reply: begin
                    // [R1] status, channel, checksum, end
                    if (tx_ready) begin
                        st_nxt.ridx = st_r.ridx + 2'h1;
                        case (st_r.ridx)
                            2'h0: st_nxt.tx = st_r.chan;
                            2'h1: st_nxt.tx = chk_sum;
                            2'h2: st_nxt.tx = `TS_ETX;
                            default: st_nxt.tx = st_r.tx;
                        endcase
                        if (st_r.ridx == `TS_RESP_LEN) begin
                            st_nxt.phase = ph_parse;
                            st_nxt.pos   = `TS_POS_CMD0;
                            st_nxt.err   = 1'b0;
                        end
                    end
                end

                default: begin
                    st_nxt.phase = ph_parse;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r.phase   <= ph_parse;
            st_r.loaded  <= 1'b0;
            st_r.pos     <= `TS_POS_CMD0;
            st_r.err     <= 1'b0;
            st_r.chan    <= 8'h00;
            st_r.cand    <= 16'h0000;
            st_r.status  <= 8'h00;
            st_r.ridx    <= 2'h0;
            st_r.tx      <= 8'h00;
            st_r.nv_wr   <= 1'b0;
            st_r.nv_mask <= '0;
            st_r.nv_kind <= 16'h0000;
            for (int i = 0; i < NUM_CH; i++) begin
                // [R8] factory default kind
                st_r.kind[i] <= `TS_KIND_DEFER;
            end
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign tx_valid    = (st_r.phase == ph_reply) && st_r.loaded;
    assign tx_data     = st_r.tx;
    // gated with ce so a frozen cycle does not repeat the write
    assign nv_wr_valid = st_r.nv_wr && ce;
    assign nv_wr_mask  = st_r.nv_mask;
    assign nv_wr_kind  = st_r.nv_kind;
    // [R7] code 99 passed on and flagged as deferral
    assign head_kind   = st_r.kind;

endmodule // rfid_tag_type_selector

// ===== dv/rfid_tag_type_selector_monitor.sv
/* port checker of the tag-kind selector
   assumes the bind below attaches it to every selector instance */
`include "tag_sel_regs.svh"
module rfid_tag_type_selector_monitor import tag_sel_pkg::*; #(
    parameter int NUM_CH = 4
) (
    input wire logic                                    clk_sys,          // clock
    input wire logic                                    reset_n,          // reset, active low
    input wire logic                                    ce,               // clock enable
    input wire logic                                    tx_valid,         // reply present
    input wire logic [7:0]                              tx_data,          // reply byte
    input wire logic                                    tx_ready,         // reply taken
    input wire logic                                    factory_reset,    // restore kinds
    input wire logic                                    nv_wr_valid,      // store write
    input wire logic [NUM_CH-1:0]                       nv_wr_mask,       // channels written
    input wire tag_sel_pkg::kind_code_type              nv_wr_kind,       // kind written
    input wire tag_sel_pkg::kind_code_type [NUM_CH-1:0] head_kind,        // kind per head
    input wire logic [NUM_CH-1:0]                       head_defer,       // head default
    input wire logic [NUM_CH-1:0]                       head_uid_only,    // uid only
    input wire logic [NUM_CH-1:0][3:0]                  head_block_bytes  // block size
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_defer_flag:
    assert property (head_defer[0] == (head_kind[0] == `TS_KIND_DEFER)) else $error("defer flag wrong");
    a_uid_only_flag:
    assert property (head_uid_only[0] == (head_kind[0] == 16'h3230)) else $error("uid flag wrong");
    a_block_size:
    assert property (head_block_bytes[0] == ((head_kind[0] == 16'h3333) ? `TS_BLOCK_WIDE : `TS_BLOCK_STD))
        else $error("block size wrong");
    a_factory_store:
    assert property (factory_reset && ce |=> nv_wr_valid && &nv_wr_mask && nv_wr_kind == `TS_KIND_DEFER)
        else $error("factory restore not stored");
    a_store_pulse:
    assert property (nv_wr_valid && !factory_reset |=> !nv_wr_valid) else $error("store pulse too long");
    a_store_matches:
    assert property (nv_wr_valid && nv_wr_mask[0] |-> head_kind[0] == nv_wr_kind) else $error("store differs");
    a_reply_holds:
    assert property (tx_valid && !tx_ready && !factory_reset |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped");
    a_reply_status:
    assert property (nv_wr_valid && !$past(factory_reset) |-> tx_valid && tx_data == `TS_ST_OK)
        else $error("no ok status after change");

    c_all_write: cover property (nv_wr_valid && &nv_wr_mask);
    c_bad_status: cover property (tx_valid && tx_data == `TS_ST_BAD);
    c_wide_block: cover property (head_block_bytes[0] == `TS_BLOCK_WIDE);
endmodule // rfid_tag_type_selector_monitor

bind rfid_tag_type_selector rfid_tag_type_selector_monitor #(.NUM_CH(NUM_CH)) u_mon (
    .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .factory_reset(factory_reset), .nv_wr_valid(nv_wr_valid),
    .nv_wr_mask(nv_wr_mask), .nv_wr_kind(nv_wr_kind), .head_kind(head_kind), .head_defer(head_defer),
    .head_uid_only(head_uid_only), .head_block_bytes(head_block_bytes));

// ===== dv/host_link_model.sv
/* host side of the command byte link: sends telegrams, collects replies
   assumes tasks are called just after a rising edge of clk_sys */
`include "tag_sel_regs.svh"
module host_link_model (
    input  wire logic       clk_sys,  // system clock
    output      logic       rx_valid, // byte offered
    output      logic [7:0] rx_data,  // byte
    input  wire logic       rx_ready, // byte taken
    input  wire logic       tx_valid, // reply present
    input  wire logic [7:0] tx_data,  // reply byte
    output      logic       tx_ready  // reply taken
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h55;
        tx_ready = 1'b0;
    end

    task automatic send(input string s);
        logic [7:0] b;
        int         n;
        @(posedge clk_sys);
        for (int i = 0; i <= s.len(); i++) begin
            b = (i == s.len()) ? `TS_ETX : 8'(s[i]);
            rx_valid <= 1'b1;
            rx_data <= b;
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (!rx_ready && n < 200);
        end
        rx_valid <= 1'b0;
        // released line shows the inverse
        rx_data <= ~b;
    endtask

    task automatic recv(input int stall, output logic [31:0] r);
        int n;
        r = '0;
        for (int i = 0; i < 4; i++) begin
            n = 0;
            do begin
                @(posedge clk_sys);
                n++;
            end while (!tx_valid && n < 200);
            repeat (stall) @(posedge clk_sys);
            tx_ready <= 1'b1;
            @(posedge clk_sys);
            r = {r[23:0], tx_data};
            tx_ready <= 1'b0;
        end
    endtask
endmodule // host_link_model

// ===== dv/test_rfid_tag_type_selector.sv
/* bench of the tag-kind selector with host model and bound checker
   assumes header, package, interface, design and checker compiled first */
`include "tag_sel_regs.svh"
module test_rfid_tag_type_selector;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int NCH = 4;
    logic                                 clk_sys, reset_n, ce, factory_reset;
    logic                                 rx_valid, rx_ready, tx_valid, tx_ready, nv_wr_valid;
    logic [7:0]                           rx_data, tx_data;
    logic [NCH-1:0]                       nv_wr_mask, head_defer, head_uid_only, head_uid_flex;
    logic [NCH-1:0][3:0]                  head_block_bytes;
    tag_sel_pkg::kind_code_type           nv_wr_kind;
    tag_sel_pkg::kind_code_type [NCH-1:0] nv_load_kind, head_kind;
    int                                   failures, n_checks, cycles;

    rfid_tag_type_selector #(.NUM_CH(NCH)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .factory_reset(factory_reset), .nv_load_kind(nv_load_kind), .nv_wr_valid(nv_wr_valid),
        .nv_wr_mask(nv_wr_mask), .nv_wr_kind(nv_wr_kind), .head_kind(head_kind), .head_defer(head_defer),
        .head_uid_only(head_uid_only), .head_uid_flex(head_uid_flex), .head_block_bytes(head_block_bytes));

    host_link_model HOST (
        .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic chk_kind(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_reply(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: reply %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            stop_test();
        end
    end

    // one telegram, whole reply, status and checksum judged
    task automatic xfer(input string s, input int stall, input logic [7:0] st);
        logic [31:0] r;
        HOST.send(s);
        HOST.recv(stall, r);
        chk_reply(r, {st, 8'(s[2]), 8'(st + 8'(s[2])), `TS_ETX});
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_load();
        for (int i = 0; i < NCH; i++) chk_kind(head_kind[i], nv_load_kind[i]);
        chk_kind(16'(head_block_bytes[0]), 16'h8);
        chk_kind(16'(head_uid_only), 16'h2);
    endtask

    task automatic t_codes();
        string       c = "0203111220212223243133343540414243505272737475768099";
        string       p;
        logic [15:0] k;
        logic [15:0] f;
        for (int i = 0; i < c.len(); i += 2) begin
            k = {8'(c[i]), 8'(c[i+1])};
            p = (i % 4 != 0) ? "cT" : "Ct";
            xfer({p, "2", c.substr(i, i + 1), "k"}, i % 3, `TS_ST_OK);
            chk_kind(head_kind[1], k);
            f = {13'h0, k == 16'h3939, k == 16'h3230, k == 16'h3430 || k == 16'h3432 || k == 16'h3433};
            chk_kind({13'h0, head_defer[1], head_uid_only[1], head_uid_flex[1]}, f);
            chk_kind(16'(head_block_bytes[1]), (k == 16'h3333) ? 16'h8 : 16'h4);
        end
    endtask

    task automatic t_all();
        xfer("CTx33k", 0, `TS_ST_OK);
        for (int i = 0; i < NCH; i++) chk_kind(head_kind[i], 16'h3333);
        chk_kind(16'(nv_wr_mask), 16'hf);
        chk_kind(nv_wr_kind, 16'h3333);
    endtask

    task automatic t_bad();
        string bad[6] = '{"CT119k", "CT533k", "CT 33k", "CX133k", "CT13Ak", "CT13k"};
        foreach (bad[i]) begin
            xfer(bad[i], 1, `TS_ST_BAD);
            chk_kind(head_kind[0], 16'h3333);
            chk_kind(head_kind[3], 16'h3333);
        end
    endtask

    // factory restore aborts a reply that the host has not collected
    task automatic t_factory();
        HOST.send("CT133k");
        @(posedge clk_sys);
        factory_reset <= 1'b1;
        @(posedge clk_sys);
        factory_reset <= 1'b0;
        @(posedge clk_sys);
        chk_kind(16'(tx_valid), 16'h0);
        for (int i = 0; i < NCH; i++) chk_kind(head_kind[i], `TS_KIND_DEFER);
        chk_kind(16'(head_defer), 16'hf);
        xfer("ct120k", 2, `TS_ST_OK);
        chk_kind(16'(head_uid_only), 16'h1);
    endtask

    initial begin
        reset_n = 1'b0;
        ce = 1'b0;
        factory_reset = 1'b0;
        nv_load_kind = {16'h3939, 16'h3032, 16'h3230, 16'h3333};
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        chk_kind(head_kind[0], `TS_KIND_DEFER);
        ce <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_load();
        t_codes();
        t_all();
        t_bad();
        t_factory();
        stop_test();
    end
endmodule // test_rfid_tag_type_selector
